// file: tpgc_pkg.sv
`default_nettype none
package tpgc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_LOCK_CLEAR   = 10'h11f;
   localparam logic [9:0] IDX_CHK_ERR_HIGH = 10'h122;
   localparam logic [9:0] IDX_GEN_CFG      = 10'h123;
   localparam logic [9:0] IDX_PATTERN_LOW  = 10'h124;
   localparam logic [9:0] IDX_PATTERN_MID  = 10'h125;
   localparam logic [9:0] IDX_PATTERN_HIGH = 10'h126;
   localparam logic [9:0] IDX_MATCH_LOW    = 10'h127;
   localparam logic [9:0] IDX_MATCH_MID    = 10'h128;
   localparam logic [9:0] IDX_MATCH_HIGH   = 10'h129;
   localparam logic [9:0] IDX_CRC_FLAGS    = 10'h12a;
   localparam logic [9:0] IDX_TX_CNT_LOW   = 10'h12b;
   localparam logic [9:0] IDX_TX_CNT_HIGH  = 10'h12c;
   localparam logic [9:0] IDX_TX_ERR_CNT   = 10'h12d;
   localparam logic [9:0] IDX_RX_CNT_LOW   = 10'h12e;
   localparam logic [9:0] IDX_RX_CNT_HIGH  = 10'h12f;
   localparam logic [9:0] IDX_RX_ERR_CNT   = 10'h130;
   localparam logic [9:0] IDX_CHK_MODE     = 10'h131;
   localparam logic [9:0] IDX_IRQ_STATUS   = 10'h132;
   localparam logic [9:0] IDX_IRQ_MASK     = 10'h133;

   // Field positions of the generator configuration word
   localparam int FIXED_BYTE_LSB = 8;
   localparam int PAY_MODE_LSB   = 6;
   localparam int PAT_BYTES_LSB  = 3;
   localparam int PKT_CODE_LSB   = 0;
   localparam logic [2:0] PAT_BYTES_MAX = 3'h6;
   localparam logic [2:0] PKT_CODE_CONT = 3'h7;

   // Lock and clear bits, interrupt bits, mode bits
   localparam int LOCK_BIT    = 0;
   localparam int CLEAR_BIT   = 1;
   localparam int IRQ_TX_CRC  = 0;
   localparam int IRQ_RX_CRC  = 1;
   localparam int IRQ_CHK_OVF = 2;
   localparam int IRQ_W       = 3;
   localparam int MODE_WRAP_BIT = 0;
   localparam int MODE_OVF_BIT  = 1;

   localparam logic [15:0] RST_16 = 16'h0000;
   localparam logic [7:0]  PRBS_SEED = 8'hff;

   typedef enum logic [1:0] {
      TPGC_SEQ_IDLE = 2'b00,
      TPGC_SEQ_LOW  = 2'b01,
      TPGC_SEQ_HIGH = 2'b10
   } tpgc_seq_t;
endpackage
`default_nettype wire

// file: tpgc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tpgc_top
   import tpgc_pkg::*;
#(
   parameter int ADDR_W = 12
)(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   output logic                   irq,
   input  wire logic              tx_pkt_done,
   input  wire logic              tx_pkt_crc_err,
   input  wire logic              rx_pkt_done,
   input  wire logic              rx_pkt_crc_err,
   input  wire logic              chk_err_pkt,
   input  wire logic              payload_start,
   input  wire logic              payload_advance,
   output logic      [7:0]        payload_byte,
   output logic      [2:0]        pattern_bytes,
   output logic      [19:0]       pkt_target,
   output logic                   pkt_continuous,
   output logic      [47:0]       pattern,
   input  wire logic              rx_dest_valid,
   input  wire logic [47:0]       rx_dest_addr,
   output logic                   dest_match
);
   import tpgc_pkg::*;

   if (ADDR_W < 12 || ADDR_W > 32) begin : g_addr_chk
      $error("ADDR_W must lie between 12 and 32");
   end

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // Next step of an ascending three-read clearing sequence
   function automatic tpgc_seq_t seq_step(input tpgc_seq_t cur, input logic [9:0] idx, input logic [9:0] first);
      logic [9:0] second;
      logic [9:0] third;
      second = first + 10'h001;
      third  = first + 10'h002;
      seq_step = TPGC_SEQ_IDLE;
      if (idx == first) begin
         seq_step = TPGC_SEQ_LOW;
      end else if (idx == second && cur == TPGC_SEQ_LOW) begin
         seq_step = TPGC_SEQ_HIGH;
      end else begin
         seq_step = TPGC_SEQ_IDLE;
      end
   endfunction

   function automatic logic [19:0] decade(input logic [2:0] code);
      case (code)
         3'h0:    decade = 20'h00001;
         3'h1:    decade = 20'h0000a;
         3'h2:    decade = 20'h00064;
         3'h3:    decade = 20'h003e8;
         3'h4:    decade = 20'h02710;
         3'h5:    decade = 20'h186a0;
         3'h6:    decade = 20'hf4240;
         default: decade = 20'h00000;
      endcase
   endfunction

   logic [15:0]      cfg_r;
   logic [47:0]      pattern_r;
   logic [47:0]      match_r;
   logic [31:0]      chk_cnt_r;
   logic [15:0]      chk_high_snap_r;
   logic             chk_wrap_r;
   logic             chk_ovf_r;
   logic [1:0]       crc_flags_r;
   logic [31:0]      tx_cnt_r;
   logic [15:0]      tx_err_r;
   logic [31:0]      rx_cnt_r;
   logic [15:0]      rx_err_r;
   tpgc_seq_t        tx_seq_r;
   tpgc_seq_t        rx_seq_r;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic [31:0]      rdata_r;
   logic             wait_r;
   logic             irq_r;
   logic [7:0]       pay_r;
   logic             match_hit_r;

   // Bus decode: one wait cycle, then the transfer completes
   wire        req        = avs_read | avs_write;
   wire        accept     = req & ~wait_r;
   wire        wr_acc     = accept & avs_write;
   wire        rd_acc     = accept & avs_read;
   wire [9:0]  idx        = avs_address[11:2];

   wire [1:0]  pay_mode   = cfg_r[PAY_MODE_LSB +: 2];
   wire [7:0]  fixed_byte = cfg_r[FIXED_BYTE_LSB +: 8];
   wire [2:0]  pat_field  = cfg_r[PAT_BYTES_LSB +: 3];
   wire [2:0]  pkt_code   = cfg_r[PKT_CODE_LSB +: 3];

   wire lock_wr  = wr_acc && idx == IDX_LOCK_CLEAR && avs_byteenable[0]
                   && (avs_writedata[LOCK_BIT] || avs_writedata[CLEAR_BIT]);
   wire clear_wr = lock_wr && avs_writedata[CLEAR_BIT];

   // Checker errored-packet counter: wrap or saturate
   wire        chk_full   = chk_cnt_r == 32'hffffffff;
   wire [31:0] chk_inc    = (chk_full && !chk_wrap_r) ? chk_cnt_r : chk_cnt_r + 32'h00000001;
   wire [31:0] chk_nxt    = clear_wr ? 32'h00000000 : (chk_err_pkt ? chk_inc : chk_cnt_r);
   wire        chk_ovf_ev = chk_err_pkt && chk_full && !clear_wr;

   // Clearing sequences advance only on completed reads
   wire tpgc_seq_t tx_seq_nxt = rd_acc ? seq_step(tx_seq_r, idx, IDX_TX_CNT_LOW) : tx_seq_r;
   wire tpgc_seq_t rx_seq_nxt = rd_acc ? seq_step(rx_seq_r, idx, IDX_RX_CNT_LOW) : rx_seq_r;
   wire tx_clr = rd_acc && idx == IDX_TX_ERR_CNT && tx_seq_r == TPGC_SEQ_HIGH;
   wire rx_clr = rd_acc && idx == IDX_RX_ERR_CNT && rx_seq_r == TPGC_SEQ_HIGH;

   wire tx_crc_ev = tx_pkt_done && tx_pkt_crc_err;
   wire rx_crc_ev = rx_pkt_done && rx_pkt_crc_err;
   wire [IRQ_W-1:0] irq_events;
   assign irq_events[IRQ_TX_CRC]  = tx_crc_ev;
   assign irq_events[IRQ_RX_CRC]  = rx_crc_ev;
   assign irq_events[IRQ_CHK_OVF] = chk_ovf_ev;
   wire [IRQ_W-1:0] irq_w1c = (wr_acc && idx == IDX_IRQ_STATUS && avs_byteenable[0])
                              ? avs_writedata[IRQ_W-1:0] : {IRQ_W{1'b0}};
   wire [IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_w1c) | irq_events;
   // Mask write acts on irq at the same edge as a status change would
   wire             mask_wr      = wr_acc && idx == IDX_IRQ_MASK && avs_byteenable[0];
   wire [IRQ_W-1:0] irq_mask_nxt = mask_wr ? avs_writedata[IRQ_W-1:0] : irq_mask_r;

   // Read multiplexer
   logic [15:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      if (idx == IDX_CHK_ERR_HIGH) begin
         rd_mux = chk_high_snap_r;
      end else if (idx == IDX_GEN_CFG) begin
         rd_mux = cfg_r;
      end else if (idx == IDX_PATTERN_LOW) begin
         rd_mux = pattern_r[15:0];
      end else if (idx == IDX_PATTERN_MID) begin
         rd_mux = pattern_r[31:16];
      end else if (idx == IDX_PATTERN_HIGH) begin
         rd_mux = pattern_r[47:32];
      end else if (idx == IDX_MATCH_LOW) begin
         rd_mux = match_r[15:0];
      end else if (idx == IDX_MATCH_MID) begin
         rd_mux = match_r[31:16];
      end else if (idx == IDX_MATCH_HIGH) begin
         rd_mux = match_r[47:32];
      end else if (idx == IDX_CRC_FLAGS) begin
         rd_mux = {14'h0000, crc_flags_r};
      end else if (idx == IDX_TX_CNT_LOW) begin
         rd_mux = tx_cnt_r[15:0];
      end else if (idx == IDX_TX_CNT_HIGH) begin
         rd_mux = tx_cnt_r[31:16];
      end else if (idx == IDX_TX_ERR_CNT) begin
         rd_mux = tx_err_r;
      end else if (idx == IDX_RX_CNT_LOW) begin
         rd_mux = rx_cnt_r[15:0];
      end else if (idx == IDX_RX_CNT_HIGH) begin
         rd_mux = rx_cnt_r[31:16];
      end else if (idx == IDX_RX_ERR_CNT) begin
         rd_mux = rx_err_r;
      end else if (idx == IDX_CHK_MODE) begin
         rd_mux = {14'h0000, chk_ovf_r, chk_wrap_r};
      end else if (idx == IDX_IRQ_STATUS) begin
         rd_mux = {13'h0000, irq_stat_r};
      end else if (idx == IDX_IRQ_MASK) begin
         rd_mux = {13'h0000, irq_mask_r};
      end else begin
         rd_mux = RST_16;
         rd_hit = 1'b0;
      end
   end

   // Payload byte source
   wire [7:0] prbs_next = {pay_r[6:0], pay_r[7] ^ pay_r[5] ^ pay_r[4] ^ pay_r[3]};
   wire [7:0] pay_first = pay_mode[1] ? PRBS_SEED : (pay_mode[0] ? fixed_byte : 8'h00);
   wire [7:0] pay_step  = pay_mode[1] ? prbs_next : (pay_mode[0] ? fixed_byte : pay_r + 8'h01);
   wire [7:0] pay_nxt   = payload_start ? pay_first : (payload_advance ? pay_step : pay_r);

   wire [2:0] pat_clamped = (pat_field > PAT_BYTES_MAX) ? PAT_BYTES_MAX : pat_field;

   // Bus handshake and read data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         wait_r  <= ~(req & wait_r);
         rdata_r <= (avs_read & wait_r & rd_hit) ? {16'h0000, rd_mux} : 32'h00000000;
      end
   end

   // Software-written configuration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r      <= RST_16;
         pattern_r  <= {48{1'b0}};
         match_r    <= {48{1'b0}};
         chk_wrap_r <= 1'b0;
         irq_mask_r <= {IRQ_W{1'b0}};
      end else if (wr_acc) begin
         if (idx == IDX_GEN_CFG) cfg_r <= merge16(cfg_r, avs_writedata, avs_byteenable);
         if (idx == IDX_PATTERN_LOW) pattern_r[15:0] <= merge16(pattern_r[15:0], avs_writedata, avs_byteenable);
         if (idx == IDX_PATTERN_MID) pattern_r[31:16] <= merge16(pattern_r[31:16], avs_writedata, avs_byteenable);
         if (idx == IDX_PATTERN_HIGH) pattern_r[47:32] <= merge16(pattern_r[47:32], avs_writedata, avs_byteenable);
         if (idx == IDX_MATCH_LOW) match_r[15:0] <= merge16(match_r[15:0], avs_writedata, avs_byteenable);
         if (idx == IDX_MATCH_MID) match_r[31:16] <= merge16(match_r[31:16], avs_writedata, avs_byteenable);
         if (idx == IDX_MATCH_HIGH) match_r[47:32] <= merge16(match_r[47:32], avs_writedata, avs_byteenable);
         if (idx == IDX_CHK_MODE && avs_byteenable[0]) chk_wrap_r <= avs_writedata[MODE_WRAP_BIT];
         if (idx == IDX_IRQ_MASK && avs_byteenable[0]) irq_mask_r <= avs_writedata[IRQ_W-1:0];
      end
   end

   // Checker counter, freeze snapshot and overflow
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_cnt_r       <= 32'h00000000;
         chk_high_snap_r <= RST_16;
         chk_ovf_r       <= 1'b0;
      end else begin
         chk_cnt_r <= chk_nxt;
         if (lock_wr) chk_high_snap_r <= chk_cnt_r[31:16];
         chk_ovf_r <= chk_ovf_ev | (chk_ovf_r & ~clear_wr);
      end
   end

   // Packet statistics and CRC flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_cnt_r    <= 32'h00000000;
         tx_err_r    <= RST_16;
         rx_cnt_r    <= 32'h00000000;
         rx_err_r    <= RST_16;
         crc_flags_r <= 2'h0;
         tx_seq_r    <= TPGC_SEQ_IDLE;
         rx_seq_r    <= TPGC_SEQ_IDLE;
      end else begin
         tx_seq_r <= tx_seq_nxt;
         rx_seq_r <= rx_seq_nxt;
         tx_cnt_r <= (tx_clr ? 32'h00000000 : tx_cnt_r) + {31'h0, tx_pkt_done};
         tx_err_r <= (tx_clr ? RST_16 : tx_err_r) + {15'h0, tx_crc_ev};
         rx_cnt_r <= (rx_clr ? 32'h00000000 : rx_cnt_r) + {31'h0, rx_pkt_done};
         rx_err_r <= (rx_clr ? RST_16 : rx_err_r) + {15'h0, rx_crc_ev};
         if (tx_pkt_done) crc_flags_r[0] <= tx_pkt_crc_err;
         if (rx_pkt_done) crc_flags_r[1] <= rx_pkt_crc_err;
      end
   end

   // Interrupt status: an event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= {IRQ_W{1'b0}};
         irq_r      <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq_r      <= |(irq_stat_nxt & irq_mask_nxt);
      end
   end

   // Generator outputs and destination match
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pay_r       <= 8'h00;
         match_hit_r <= 1'b0;
      end else begin
         pay_r       <= pay_nxt;
         match_hit_r <= rx_dest_valid ? (rx_dest_addr == match_r) : match_hit_r;
      end
   end

   logic [2:0]  pat_bytes_r;
   logic [19:0] target_r;
   logic        cont_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pat_bytes_r <= 3'h0;
         target_r    <= 20'h00001;
         cont_r      <= 1'b0;
      end else begin
         pat_bytes_r <= pat_clamped;
         target_r    <= decade(pkt_code);
         cont_r      <= pkt_code == PKT_CODE_CONT;
      end
   end

   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;
   assign irq             = irq_r;
   assign payload_byte    = pay_r;
   assign pattern_bytes   = pat_bytes_r;
   assign pkt_target      = target_r;
   assign pkt_continuous  = cont_r;
   assign pattern         = pattern_r;
   assign dest_match      = match_hit_r;
endmodule
`default_nettype wire

// file: tpgc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tpgc_checker
   import tpgc_pkg::*;
#(
   parameter int ADDR_W = 12
)(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_writedata,
   input wire logic [3:0]        avs_byteenable,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              irq,
   input wire logic              tx_pkt_done,
   input wire logic              tx_pkt_crc_err,
   input wire logic              rx_pkt_done,
   input wire logic              rx_pkt_crc_err,
   input wire logic              chk_err_pkt,
   input wire logic [2:0]        pattern_bytes,
   input wire logic [19:0]       pkt_target,
   input wire logic              pkt_continuous,
   input wire logic [47:0]       pattern,
   input wire logic              rx_dest_valid,
   input wire logic              dest_match
);
   wire logic [9:0] idx   = avs_address[11:2];
   wire logic       rd_ok = avs_read && !avs_waitrequest;
   wire logic       wr_ok = avs_write && !avs_waitrequest;
   wire logic       wr_16 = wr_ok && (avs_byteenable[1:0] == 2'h3);
   wire logic [2:0] clamp = (avs_writedata[5:3] > PAT_BYTES_MAX) ? PAT_BYTES_MAX : avs_writedata[5:3];
   wire logic       ev    = (tx_pkt_done && tx_pkt_crc_err) || (rx_pkt_done && rx_pkt_crc_err) || chk_err_pkt || wr_ok;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   AST_HS: assert property (s_req |=> s_ack) else $error("waitrequest not low for one cycle");
   AST_CRC_RSVD: assert property (rd_ok && idx == IDX_CRC_FLAGS |-> avs_readdata[31:2] == 30'h0)
      else $error("flag register upper bits not zero");
   AST_LOCK_WO: assert property (rd_ok && idx == IDX_LOCK_CLEAR |-> avs_readdata == 32'h0)
      else $error("lock register read not zero");
   AST_PAT_MAX: assert property (pattern_bytes <= PAT_BYTES_MAX) else $error("pattern bytes above six");
   AST_CFG_BYTES: assert property (wr_16 && idx == IDX_GEN_CFG |-> ##2 pattern_bytes == $past(clamp, 2))
      else $error("pattern bytes not taken from config");
   AST_CONT: assert property (pkt_continuous == (pkt_target == 20'h0)) else $error("continuous flag mismatch");
   AST_PAT_WR: assert property (wr_16 && idx == IDX_PATTERN_MID |=> pattern[31:16] == $past(avs_writedata[15:0]))
      else $error("pattern middle word not written");
   AST_MATCH_HOLD: assert property (!rx_dest_valid |=> $stable(dest_match)) else $error("match changed unasked");
   AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(ev)) else $error("irq rose without cause");
endmodule
`default_nettype wire

// file: tpgc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpgc_link_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       go,
   input  wire logic [1:0] kind,
   input  wire logic       crc,
   input  wire logic [7:0] n,
   input  wire logic       slow,
   output logic            busy,
   output logic            tx_pkt_done,
   output logic            tx_pkt_crc_err,
   output logic            rx_pkt_done,
   output logic            rx_pkt_crc_err,
   output logic            chk_err_pkt
);
   logic [7:0] left_r;
   logic       ph_r;
   logic       fire;
   // Slow mode leaves an idle cycle between events
   assign fire           = (left_r != 8'h00) && (ph_r || !slow);
   assign busy           = (left_r != 8'h00);
   assign tx_pkt_done    = fire && (kind == 2'h0);
   assign rx_pkt_done    = fire && (kind == 2'h1);
   assign chk_err_pkt    = fire && (kind == 2'h2);
   // Qualifiers show the opposite level in cycles when no event fires
   assign tx_pkt_crc_err = fire ? crc : !crc;
   assign rx_pkt_crc_err = fire ? crc : !crc;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         left_r <= 8'h00;
         ph_r   <= 1'b0;
      end else if (go) begin
         left_r <= n;
         ph_r   <= 1'b0;
      end else begin
         ph_r <= !ph_r;
         if (fire) begin
            left_r <= left_r - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// file: test_packet_gen_and_counters_tb.sv
`timescale 1ns/1ps
`default_nettype none
module test_packet_gen_and_counters_tb;
   import tpgc_pkg::*;
   logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, irq, go, crc, slow, busy;
   logic        tx_pkt_done, tx_pkt_crc_err, rx_pkt_done, rx_pkt_crc_err, chk_err_pkt;
   logic        payload_start, payload_advance, pkt_continuous, rx_dest_valid, dest_match;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable;
   logic [7:0]  payload_byte, n;
   logic [2:0]  pattern_bytes;
   logic [19:0] pkt_target;
   logic [47:0] pattern, rx_dest_addr;
   logic [1:0]  kind;
   int          err_count, n_checks, cyc;
   logic [31:0] expn;
   logic [7:0]  p0 [4] = '{8'h00, 8'ha5, 8'hff, 8'hff};
   logic [7:0]  p1 [4] = '{8'h01, 8'ha5, 8'hfe, 8'hfe};
   tpgc_top #(.ADDR_W(12)) u_dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .tx_pkt_done, .tx_pkt_crc_err, .rx_pkt_done,
      .rx_pkt_crc_err, .chk_err_pkt, .payload_start, .payload_advance, .payload_byte, .pattern_bytes,
      .pkt_target, .pkt_continuous, .pattern, .rx_dest_valid, .rx_dest_addr, .dest_match);
   tpgc_link_model u_link (.clk, .rst_n, .go, .kind, .crc, .n, .slow, .busy, .tx_pkt_done, .tx_pkt_crc_err,
      .rx_pkt_done, .rx_pkt_crc_err, .chk_err_pkt);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic test_done;
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [9:0] i, input logic [15:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= {i, 2'h0};
      avs_writedata <= {16'h0000, d};
      avs_read <= !w;
      avs_write <= w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] i, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask
   task automatic rd(input logic [9:0] i, input logic [15:0] e);
      logic [31:0] q;
      bus(1'b0, i, 16'h0000, q);
      chk($sformatf("register %h", i), {32'h0, e}, {16'h0, q});
   endtask
   task automatic pk(input logic [1:0] k, input logic c, input logic [7:0] m, input logic s);
      @(posedge clk);
      kind <= k;
      crc <= c;
      n <= m;
      slow <= s;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      while (busy) @(negedge clk);
   endtask
   task automatic pl(input logic st, input logic [7:0] e);
      @(posedge clk);
      payload_start <= st;
      payload_advance <= !st;
      @(posedge clk);
      payload_start <= 1'b0;
      payload_advance <= 1'b0;
      @(negedge clk);
      chk("payload_byte", 48'(e), 48'(payload_byte));
   endtask
   task automatic dm(input logic [47:0] a, input logic e);
      @(posedge clk);
      rx_dest_valid <= 1'b1;
      rx_dest_addr <= a;
      @(posedge clk);
      rx_dest_valid <= 1'b0;
      rx_dest_addr <= ~a;
      @(negedge clk);
      chk("dest_match", 48'(e), 48'(dest_match));
   endtask
   initial begin
      {rst_n, avs_read, avs_write, go, crc, slow, payload_start, payload_advance, rx_dest_valid} = '0;
      {avs_address, avs_writedata, n, kind, rx_dest_addr, err_count, n_checks, cyc} = '0;
      avs_byteenable = 4'hf;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 'h122; i <= 'h130; i++) rd(i[9:0], 16'h0000);
      rd(10'h3ff, 16'h0000);
      $display("test reset done");
      wr(IDX_GEN_CFG, 16'ha57e);
      rd(IDX_GEN_CFG, 16'ha57e);
      chk("pattern_bytes", 48'h6, 48'(pattern_bytes));
      expn = 32'h1;
      for (int c = 0; c < 8; c++) begin
         wr(IDX_GEN_CFG, {13'h0, c[2:0]});
         repeat (2) @(negedge clk);
         chk("pkt_target", (c == 7) ? 48'h0 : 48'(expn), 48'(pkt_target));
         chk("pkt_continuous", 48'(c == 7), 48'(pkt_continuous));
         expn = expn * 10;
      end
      for (int m = 0; m < 4; m++) begin
         wr(IDX_GEN_CFG, {8'ha5, m[1:0], 6'h00});
         pl(1'b1, p0[m]);
         pl(1'b0, p1[m]);
      end
      $display("test generator config done");
      wr(IDX_PATTERN_LOW, 16'h3210);
      wr(IDX_PATTERN_MID, 16'h7654);
      wr(IDX_PATTERN_HIGH, 16'hba98);
      @(negedge clk);
      chk("pattern", 48'hba98_7654_3210, pattern);
      rd(IDX_PATTERN_MID, 16'h7654);
      avs_byteenable <= 4'h2;
      wr(IDX_PATTERN_LOW, 16'hffff);
      avs_byteenable <= 4'hf;
      rd(IDX_PATTERN_LOW, 16'hff10);
      wr(IDX_MATCH_LOW, 16'h9abc);
      wr(IDX_MATCH_MID, 16'h5678);
      wr(IDX_MATCH_HIGH, 16'h1234);
      dm(48'h1234_5678_9abc, 1'b1);
      dm(48'h1235_5678_9abc, 1'b0);
      $display("test pattern and match done");
      pk(2'h0, 1'b1, 8'h03, 1'b1);
      pk(2'h0, 1'b0, 8'h02, 1'b0);
      chk("irq", 48'h0, 48'(irq));
      wr(IDX_IRQ_MASK, 16'h0001);
      repeat (2) @(negedge clk);
      chk("irq", 48'h1, 48'(irq));
      wr(IDX_IRQ_STATUS, 16'h0001);
      repeat (2) @(negedge clk);
      chk("irq", 48'h0, 48'(irq));
      wr(IDX_CRC_FLAGS, 16'hffff);
      rd(IDX_CRC_FLAGS, 16'h0000);
      rd(IDX_TX_CNT_LOW, 16'h0005);
      rd(IDX_TX_CNT_HIGH, 16'h0000);
      rd(IDX_TX_ERR_CNT, 16'h0003);
      rd(IDX_TX_CNT_LOW, 16'h0000);
      rd(IDX_TX_ERR_CNT, 16'h0000);
      $display("test transmit counters done");
      pk(2'h1, 1'b1, 8'h02, 1'b0);
      rd(IDX_CRC_FLAGS, 16'h0002);
      rd(IDX_RX_CNT_LOW, 16'h0002);
      rd(IDX_CRC_FLAGS, 16'h0002);
      rd(IDX_RX_CNT_HIGH, 16'h0000);
      rd(IDX_RX_ERR_CNT, 16'h0002);
      rd(IDX_RX_CNT_LOW, 16'h0002);
      rd(IDX_RX_CNT_HIGH, 16'h0000);
      rd(IDX_RX_ERR_CNT, 16'h0002);
      rd(IDX_RX_CNT_LOW, 16'h0000);
      rd(IDX_RX_ERR_CNT, 16'h0000);
      $display("test receive counters done");
      wr(IDX_CHK_MODE, 16'h0001);
      rd(IDX_CHK_MODE, 16'h0001);
      pk(2'h2, 1'b0, 8'h03, 1'b0);
      wr(IDX_LOCK_CLEAR, 16'h0002);
      rd(IDX_CHK_ERR_HIGH, 16'h0000);
      rd(IDX_LOCK_CLEAR, 16'h0000);
      $display("test checker lock done");
      test_done();
   end
endmodule
bind tpgc_top tpgc_checker #(.ADDR_W(ADDR_W)) u_chk (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .tx_pkt_done, .tx_pkt_crc_err,
   .rx_pkt_done, .rx_pkt_crc_err, .chk_err_pkt, .pattern_bytes, .pkt_target, .pkt_continuous, .pattern,
   .rx_dest_valid, .dest_match);
`default_nettype wire
